/* File: fw_loader_pci_config_header_tb.sv */
`timescale 1ns/1ps

module fw_loader_pci_config_header_tb
   import fwl_cfg_pkg::*;
();
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic cfg_req, cfg_wr, cfg_ack, cfg_hit, ee_load;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, io_window_base, base_m, ident_m;
   logic [15:0] ee_board_maker, ee_board_model, board_maker_ident, board_model_ident;
   logic [32:0] expq[$];
   logic [7:0] rd_list[8] = '{8'h0c, 8'h10, 8'h18, 8'h2c, 8'h30, 8'h34, 8'h3c, 8'hf8};
   logic [7:0] ro_list[4] = '{8'h0c, 8'h2c, 8'h34, 8'h3c};
   logic [7:0] out_list[5] = '{8'h00, 8'h08, 8'h40, 8'h80, 8'hfc};
   int err_count = 0;
   int checks = 0;

   always #4 core_clk = ~core_clk;

   fwl_host_model host (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack));

   fwl_cfg_header DUT (.core_clk(core_clk), .rstn(rstn), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
      .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .ee_load(ee_load),
      .ee_board_maker(ee_board_maker), .ee_board_model(ee_board_model),
      .io_window_base(io_window_base), .board_maker_ident(board_maker_ident),
      .board_model_ident(board_model_ident));

   ////////////////////////////////////////////////////////////////////////////////
   // Expected contents, kept apart from the design
   function automatic logic [31:0] model_rd(logic [7:0] a);
      case (a[7:2])
         6'h03: return {VAL_SELF_TEST_CODE, VAL_HEADER_LAYOUT_TYPE, VAL_BUS_LATENCY_COUNT,
            VAL_CACHE_LINE_BYTES};
         6'h04: return base_m;
         6'h0b, 6'h3e: return ident_m;
         6'h0d: return {24'h000000, VAL_CAPABILITY_LIST_START};
         6'h0f: return {VAL_ACCESS_INTERVAL_NEED, VAL_BURST_PERIOD_NEED, VAL_IRQ_REQUEST_PIN,
            VAL_IRQ_ROUTING_LINE};
         default: return 32'h00000000;
      endcase
   endfunction

   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
      for (int i = 0; i < 4; i++)
         if (be[i])
            old[8*i+:8] = wd[8*i+:8];
      return old;
   endfunction

   task automatic check(logic [31:0] got, logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Write answers carry the dword as it was before the write
   task automatic xfer(logic wr, logic [7:0] a, logic [3:0] be, logic [31:0] wd);
      logic hit;
      hit = (a >= OFS_RANGE_FIRST && a <= OFS_RANGE_LAST) || a[7:2] == OFS_BOARD_IDENT_ALIAS[7:2];
      expq.push_back({hit, model_rd(a)});
      if (wr && a[7:2] == OFS_IO_WINDOW_BASE[7:2])
         base_m = (merge(base_m, wd, be) & MASK_IO_WINDOW_BASE) | RST_IO_WINDOW_BASE;
      if (wr && a[7:2] == OFS_BOARD_IDENT_ALIAS[7:2])
         ident_m = merge(ident_m, wd, be);
      host.access(wr, a, be, wd);
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      base_m = RST_IO_WINDOW_BASE;
      ident_m = RST_BOARD_IDENT;
   endtask

   task automatic tally_and_finish();
      if (expq.size() != 0)
         err_count++;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Answer monitor
   always @(posedge core_clk)
   begin
      logic [32:0] e;
      if (cfg_ack === 1'b1)
      begin
         e = expq.pop_front();
         check({31'h0, cfg_hit}, {31'h0, e[32]});
         check(cfg_rdata, e[31:0]);
      end
   end

   initial
   begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      int s;
      logic [31:0] w;
      ee_load = 1'b0;
      ee_board_maker = 16'h0000;
      ee_board_model = 16'h0000;
      s = $urandom(52818);
      do_reset();
      foreach (rd_list[i]) xfer(1'b0, rd_list[i], 4'h0, 32'h0);
      $display("test reset_values done");
      foreach (ro_list[i]) xfer(1'b1, ro_list[i], 4'hf, $urandom);
      foreach (rd_list[i]) xfer(1'b0, rd_list[i], 4'h0, 32'h0);
      $display("test read_only_writes done");
      xfer(1'b1, 8'h10, 4'hf, 32'hffffffff);
      for (int i = 0; i < 6; i++)
      begin
         xfer(1'b1, 8'h10, 4'($urandom), $urandom);
         xfer(1'b0, 8'h10, 4'h0, 32'h0);
      end
      check(io_window_base, base_m);
      $display("test window_base done");
      w = $urandom;
      @(posedge core_clk);
      ee_load <= 1'b1;
      ee_board_maker <= w[15:0];
      ee_board_model <= w[31:16];
      @(posedge core_clk);
      ee_load <= 1'b0;
      {ee_board_model, ee_board_maker} <= ~w;
      ident_m = w;
      xfer(1'b0, 8'h2c, 4'h0, 32'h0);
      xfer(1'b1, 8'hf8, 4'hf, $urandom);
      xfer(1'b0, 8'h2c, 4'h0, 32'h0);
      xfer(1'b0, 8'hf8, 4'h0, 32'h0);
      check({board_model_ident, board_maker_ident}, ident_m);
      $display("test board_ident done");
      foreach (out_list[i]) xfer(1'b1, out_list[i], 4'hf, $urandom);
      foreach (out_list[i]) xfer(1'b0, out_list[i], 4'h0, 32'h0);
      $display("test outside_range done");
      xfer(1'b1, 8'h10, 4'hf, $urandom);
      do_reset();
      xfer(1'b0, 8'h10, 4'h0, 32'h0);
      xfer(1'b0, 8'h2c, 4'h0, 32'h0);
      $display("test second_reset done");
      repeat (4) @(posedge core_clk);
      tally_and_finish();
   end
endmodule

/* File: fwl_cfg_header.sv */
`timescale 1ns/1ps

module fwl_cfg_header
   import fwl_cfg_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Configuration access from the host
   input wire logic cfg_req,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic cfg_hit,
   output logic [31:0] cfg_rdata,
   // Identity preload from the serial EEPROM
   input wire logic ee_load,
   input wire logic [15:0] ee_board_maker,
   input wire logic [15:0] ee_board_model,
   // Values used by the rest of the function
   output logic [31:0] io_window_base,
   output logic [15:0] board_maker_ident,
   output logic [15:0] board_model_ident
);

   ////////////////////////////////////////////////////////////////////////////////
   // Request handling

   fwl_state_type state_reg;
   fwl_state_type state_next;
   logic take;
   logic [5:0] take_idx;
   logic ack_reg;
   logic ack_next;
   logic hit_reg;
   logic hit_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [5:0] last_idx_reg;
   logic [5:0] last_idx_next;
   logic last_wr_reg;
   logic last_wr_next;

   // One request at a time; anything arriving in the reply cycle is dropped
   assign take = cfg_req && (state_reg == ST_IDLE);
   assign take_idx = cfg_addr[7:2];

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (cfg_req)
            begin
               state_next = ST_REPLY;
            end
         end
         ST_REPLY:
         begin
            state_next = ST_IDLE;
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Writable storage

   logic [3:0] base_be;
   logic [3:0] ident_be;
   logic [31:0] ident_wdata;
   logic [31:0] base_value;
   logic [31:0] ident_value;
   logic alias_wr;

   // Only the window base and the alias take write data; other bytes just ack
   assign base_be = (take && cfg_wr && (take_idx == OFS_IO_WINDOW_BASE[7:2])) ? cfg_be : 4'h0;
   assign alias_wr = take && cfg_wr && (take_idx == OFS_BOARD_IDENT_ALIAS[7:2]);

   // EEPROM preload wins over a host alias write in the same cycle
   always_comb
   begin
      ident_be = 4'h0;
      ident_wdata = cfg_wdata;
      if (ee_load)
      begin
         ident_be = 4'hf;
         ident_wdata = {ee_board_model, ee_board_maker};
      end
      else if (alias_wr)
      begin
         ident_be = cfg_be;
         ident_wdata = cfg_wdata;
      end
   end

   // Bit 1 and bit 0 are forced by the mask and reset value
   fwl_lane_reg #(
      .BYTES(4),
      .RESET_VALUE(RST_IO_WINDOW_BASE),
      .WRITE_MASK(MASK_IO_WINDOW_BASE)
   ) u_base (
      .core_clk(core_clk),
      .rstn(rstn),
      .wr_be(base_be),
      .wr_data(cfg_wdata),
      .value(base_value)
   );

   fwl_lane_reg #(
      .BYTES(4),
      .RESET_VALUE(RST_BOARD_IDENT),
      .WRITE_MASK(MASK_BOARD_IDENT)
   ) u_ident (
      .core_clk(core_clk),
      .rstn(rstn),
      .wr_be(ident_be),
      .wr_data(ident_wdata),
      .value(ident_value)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read decode and answer

   always_comb
   begin
      ack_next = take;
      last_idx_next = take ? take_idx : last_idx_reg;
      last_wr_next = take ? cfg_wr : last_wr_reg;
      hit_next = 1'b0;
      rdata_next = rdata_reg;
      if (take)
      begin
         hit_next = 1'b1;
         rdata_next = 32'h0000_0000;
         if (take_idx == OFS_CACHE_LINE_BYTES[7:2])
         begin
            rdata_next = {VAL_SELF_TEST_CODE, VAL_HEADER_LAYOUT_TYPE,
                          VAL_BUS_LATENCY_COUNT, VAL_CACHE_LINE_BYTES};
         end
         else if (take_idx == OFS_IO_WINDOW_BASE[7:2])
         begin
            rdata_next = base_value;
         end
         else if (take_idx == OFS_BOARD_MAKER_IDENT[7:2])
         begin
            rdata_next = ident_value;
         end
         else if (take_idx == OFS_CAPABILITY_LIST_START[7:2])
         begin
            rdata_next = {24'h00_0000, VAL_CAPABILITY_LIST_START};
         end
         else if (take_idx == OFS_IRQ_ROUTING_LINE[7:2])
         begin
            rdata_next = {VAL_ACCESS_INTERVAL_NEED, VAL_BURST_PERIOD_NEED,
                          VAL_IRQ_REQUEST_PIN, VAL_IRQ_ROUTING_LINE};
         end
         else if (take_idx == OFS_BOARD_IDENT_ALIAS[7:2])
         begin
            rdata_next = ident_value;
         end
         else if ((take_idx < OFS_RANGE_FIRST[7:2]) || (take_idx > OFS_RANGE_LAST[7:2]))
         begin
            // Outside this block: another part of the header answers
            hit_next = 1'b0;
         end
         // Unused dwords inside the range read zero
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= ST_IDLE;
         ack_reg <= 1'b0;
         hit_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         last_idx_reg <= 6'h00;
         last_wr_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         ack_reg <= ack_next;
         hit_reg <= hit_next;
         rdata_reg <= rdata_next;
         last_idx_reg <= last_idx_next;
         last_wr_reg <= last_wr_next;
      end
   end

   assign cfg_ack = ack_reg;
   assign cfg_hit = hit_reg;
   assign cfg_rdata = rdata_reg;
   assign io_window_base = base_value;
   assign board_maker_ident = ident_value[15:0];
   assign board_model_ident = ident_value[31:16];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   logic rd_done;
   assign rd_done = ack_reg && !last_wr_reg;

   cache_line_zero_a: assert property (
      rd_done && last_idx_reg == OFS_CACHE_LINE_BYTES[7:2] |-> cfg_rdata[7:0] == 8'h00)
      else $error("cache line byte not zero");

   latency_zero_a: assert property (
      rd_done && last_idx_reg == OFS_CACHE_LINE_BYTES[7:2] |-> cfg_rdata[15:8] == 8'h00)
      else $error("latency byte not zero");

   header_type_a: assert property (
      rd_done && last_idx_reg == OFS_CACHE_LINE_BYTES[7:2] |-> cfg_rdata[23:16] == 8'h80)
      else $error("header type not 80h");

   self_test_zero_a: assert property (
      rd_done && last_idx_reg == OFS_CACHE_LINE_BYTES[7:2] |-> cfg_rdata[31:24] == 8'h00)
      else $error("self test byte not zero");

   base_write_a: assert property (
      take && cfg_wr && take_idx == OFS_IO_WINDOW_BASE[7:2] && cfg_be == 4'hf
      |=> io_window_base[31:2] == $past(cfg_wdata[31:2]))
      else $error("window base not written");

   io_bit_one_a: assert property (io_window_base[0] == 1'b1)
      else $error("window base bit 0 not one");

   unused_bit_zero_a: assert property (
      rd_done && last_idx_reg == OFS_IO_WINDOW_BASE[7:2] |-> cfg_rdata[1] == 1'b0)
      else $error("window base bit 1 not zero");

   ident_ro_a: assert property (
      take && cfg_wr && take_idx == OFS_BOARD_MAKER_IDENT[7:2] && !ee_load
      |=> $stable(ident_value))
      else $error("identity changed by direct write");

   ident_alias_a: assert property (
      alias_wr && cfg_be == 4'hf && !ee_load
      |=> board_maker_ident == $past(cfg_wdata[15:0])
          && board_model_ident == $past(cfg_wdata[31:16]))
      else $error("alias write not applied");

   cap_pointer_a: assert property (
      rd_done && last_idx_reg == OFS_CAPABILITY_LIST_START[7:2]
      |-> cfg_rdata == 32'h0000_0044)
      else $error("capability pointer not 44h");

   irq_bytes_zero_a: assert property (
      rd_done && last_idx_reg == OFS_IRQ_ROUTING_LINE[7:2]
      |-> cfg_rdata[15:0] == 16'h0000)
      else $error("interrupt bytes not zero");

   grant_bytes_zero_a: assert property (
      rd_done && last_idx_reg == OFS_IRQ_ROUTING_LINE[7:2]
      |-> cfg_rdata[31:16] == 16'h0000)
      else $error("grant and latency bytes not zero");

   ro_write_done_a: assert property (
      take && cfg_wr && take_idx == OFS_CACHE_LINE_BYTES[7:2]
      |=> cfg_ack && cfg_hit ##1 !cfg_ack)
      else $error("read-only write not completed");

   // Requests are at least two cycles apart, so the read back lands two or three later
   base_read_cv: cover property (
      take && cfg_wr && take_idx == OFS_IO_WINDOW_BASE[7:2] ##[2:3]
      take && !cfg_wr && take_idx == OFS_IO_WINDOW_BASE[7:2]);
   alias_cv: cover property (alias_wr ##[2:4] rd_done);
   ee_load_cv: cover property (
      ee_load ##[1:4] rd_done && last_idx_reg == OFS_BOARD_MAKER_IDENT[7:2]);
   header_read_cv: cover property (rd_done && last_idx_reg == OFS_CACHE_LINE_BYTES[7:2]);

endmodule

/* File: fwl_cfg_pkg.sv */
package fwl_cfg_pkg;

   // Byte offsets inside the configuration space
   localparam logic [7:0] OFS_CACHE_LINE_BYTES = 8'h0c;
   localparam logic [7:0] OFS_BUS_LATENCY_COUNT = 8'h0d;
   localparam logic [7:0] OFS_HEADER_LAYOUT_TYPE = 8'h0e;
   localparam logic [7:0] OFS_SELF_TEST_CODE = 8'h0f;
   localparam logic [7:0] OFS_IO_WINDOW_BASE = 8'h10;
   localparam logic [7:0] OFS_BOARD_MAKER_IDENT = 8'h2c;
   localparam logic [7:0] OFS_BOARD_MODEL_IDENT = 8'h2e;
   localparam logic [7:0] OFS_CAPABILITY_LIST_START = 8'h34;
   localparam logic [7:0] OFS_IRQ_ROUTING_LINE = 8'h3c;
   localparam logic [7:0] OFS_IRQ_REQUEST_PIN = 8'h3d;
   localparam logic [7:0] OFS_BURST_PERIOD_NEED = 8'h3e;
   localparam logic [7:0] OFS_ACCESS_INTERVAL_NEED = 8'h3f;
   localparam logic [7:0] OFS_BOARD_IDENT_ALIAS = 8'hf8;

   // First and last byte of the header range this block owns
   localparam logic [7:0] OFS_RANGE_FIRST = 8'h0c;
   localparam logic [7:0] OFS_RANGE_LAST = 8'h3f;

   // Fixed read values
   localparam logic [7:0] VAL_CACHE_LINE_BYTES = 8'h00;
   localparam logic [7:0] VAL_BUS_LATENCY_COUNT = 8'h00;
   localparam logic [7:0] VAL_HEADER_LAYOUT_TYPE = 8'h80;
   localparam logic [7:0] VAL_SELF_TEST_CODE = 8'h00;
   localparam logic [7:0] VAL_CAPABILITY_LIST_START = 8'h44;
   localparam logic [7:0] VAL_IRQ_ROUTING_LINE = 8'h00;
   localparam logic [7:0] VAL_IRQ_REQUEST_PIN = 8'h00;
   localparam logic [7:0] VAL_BURST_PERIOD_NEED = 8'h00;
   localparam logic [7:0] VAL_ACCESS_INTERVAL_NEED = 8'h00;

   // Window base layout and reset
   localparam logic [31:0] RST_IO_WINDOW_BASE = 32'h0000_0001;
   localparam logic [31:0] MASK_IO_WINDOW_BASE = 32'hffff_fffc;
   localparam int POS_IO_INDICATOR = 0;
   localparam int POS_UNUSED_BIT = 1;

   // Board identity words, maker in the low half
   localparam logic [31:0] RST_BOARD_IDENT = 32'h0000_0000;
   localparam logic [31:0] MASK_BOARD_IDENT = 32'hffff_ffff;

   // Answer latency of the configuration port in clock cycles
   localparam int CFG_ANSWER_CYCLES = 1;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_REPLY = 2'b10
   } fwl_state_type;

endpackage

/* File: fwl_host_model.sv */
`timescale 1ns/1ps

module fwl_host_model
   import fwl_cfg_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Request to the header
   output logic cfg_req,
   output logic cfg_wr,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   // Answer from the header
   input wire logic cfg_ack
);
   initial
   begin
      cfg_req = 1'b0;
      cfg_wr = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One dword per request, held until the answer edge; afterwards the
   // qualifiers show the inverse, so a stale value never passes for a live one
   task automatic access(logic wr, logic [7:0] a, logic [3:0] be, logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      cfg_req <= 1'b1;
      cfg_wr <= wr;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= wd;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (cfg_ack !== 1'b1 && n < 8);
      cfg_req <= 1'b0;
      cfg_wr <= ~wr;
      cfg_addr <= ~a;
      cfg_be <= ~be;
      cfg_wdata <= ~wd;
   endtask
endmodule

/* File: fwl_lane_reg.sv */
`timescale 1ns/1ps

module fwl_lane_reg
   import fwl_cfg_pkg::*;
#(
   parameter int BYTES = 4,
   parameter logic [8*BYTES-1:0] RESET_VALUE = '0,
   parameter logic [8*BYTES-1:0] WRITE_MASK = '1
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Byte-lane write
   input wire logic [BYTES-1:0] wr_be,
   input wire logic [8*BYTES-1:0] wr_data,
   // Stored value
   output logic [8*BYTES-1:0] value
);

   logic [8*BYTES-1:0] value_reg;
   logic [8*BYTES-1:0] value_next;

   // Bits outside the mask keep their reset value for good
   always_comb
   begin
      value_next = value_reg;
      for (int i = 0; i < BYTES; i++)
      begin
         if (wr_be[i])
         begin
            value_next[8*i +: 8] = wr_data[8*i +: 8];
         end
      end
      value_next = (value_next & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         value_reg <= RESET_VALUE;
      end
      else
      begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;

endmodule
